// File: verilog/mpsc_pkg.sv
package mpsc_pkg;
  // ****************************************
  // clock and timing
  // ****************************************
  localparam int unsigned CLK_MHZ = 250;
  localparam int unsigned WAKE_HOLD_MS = 5000;
  localparam int unsigned WAKE_HOLD_CYC = WAKE_HOLD_MS * CLK_MHZ * 1000;
  localparam int unsigned KEY_ON_MS = 1000;
  localparam int unsigned KEY_ON_CYC = KEY_ON_MS * CLK_MHZ * 1000;
  localparam int unsigned KEY_OFF_MS = 2500;
  localparam int unsigned KEY_OFF_CYC = KEY_OFF_MS * CLK_MHZ * 1000;
  localparam int unsigned IND_DELAY_MS = 100;
  localparam int unsigned IND_DELAY_CYC = IND_DELAY_MS * CLK_MHZ * 1000;
  localparam logic [7:0] SLEEP_PERIOD_CYC = 8'hFF;
  localparam logic [7:0] SLEEP_AWAKE_CYC = 8'h10;
  localparam int unsigned CNT_W = 32;

  // ****************************************
  // pin synchroniser layout and idle levels
  // ****************************************
  localparam int unsigned SYNC_W = 3;
  localparam int unsigned SYNC_KEY = 0;
  localparam int unsigned SYNC_FSD = 1;
  localparam int unsigned SYNC_HSD = 2;
  // key bit starts low: a key must be seen released before it can arm
  localparam logic [2:0] SYNC_RST_VAL = 3'h6;

  // ****************************************
  // host commands and power states
  // ****************************************
  typedef enum logic [2:0] {
    CMD_NONE = 3'h0,
    CMD_SHUTDOWN = 3'h1,
    CMD_FAST_SHUTDOWN = 3'h2,
    CMD_DEEP_CFG_ON = 3'h3,
    CMD_DEEP_CFG_OFF = 3'h4,
    CMD_SLEEP = 3'h5,
    CMD_WAKE = 3'h6
  } mpsc_cmd_t;

  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_BOOT = 4'h1,
    ST_ON = 4'h2,
    ST_SLEEP = 4'h3,
    ST_DEEP = 4'h4,
    ST_DETACH = 4'h5,
    ST_FS_CLOSE = 4'h6,
    ST_FAST = 4'h7,
    ST_UNCOND = 4'h8
  } mpsc_state_t;
endpackage

// File: verilog/mpsc_sync_if.sv
interface mpsc_sync_if;
  logic [mpsc_pkg::SYNC_W-1:0] raw;
  logic [mpsc_pkg::SYNC_W-1:0] sync;
  modport sync_side (input raw, output sync);
  modport user_side (output raw, input sync);
endinterface

// File: verilog/mpsc_pin_sync.sv
module mpsc_pin_sync (
  input wire logic clk_in,
  input wire logic rst_in,
  mpsc_sync_if.sync_side pins
);
  // ****************************************
  // two-stage synchroniser
  // ****************************************
  logic [mpsc_pkg::SYNC_W-1:0] stage1_reg;
  logic [mpsc_pkg::SYNC_W-1:0] stage2_reg;

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      stage1_reg <= mpsc_pkg::SYNC_RST_VAL;
      stage2_reg <= mpsc_pkg::SYNC_RST_VAL;
    end else begin
      stage1_reg <= pins.raw;
      stage2_reg <= stage1_reg;
    end
  end

  assign pins.sync = stage2_reg;
endmodule // mpsc_pin_sync

// File: verilog/mpsc_power_ctrl.sv
// Notes on behaviour
// RL1 - off keeps only real-time clock, baseband unpowered; leaves only toward on
// RL2 - on state powers baseband fully and accepts host commands
// RL3 - sleep wakes processor intermittently; commands still served with added latency
// RL4 - timer expiry with deep sleep configured powers baseband down until wake
// RL5 - key held low five seconds or more wakes device from deep sleep
// RL6 - indicator shows deep sleep only when deep sleep configured beforehand
// RL7 - indicator high while powered, not forceable low, low in deep sleep
// RL8 - real-time clock runs while supply present; settings lost when supply drops
// RL9 - enabled fast-shutdown pin falling edge starts fast shutdown
// RL10 - fast shutdown closes file storage only, skipping slow detach
// RL11 - fast shutdown command also starts fast shutdown
// RL12 - normal shutdown detaches from network, closes file storage, then powers off
// RL13 - host powers off by shutdown command or key sequence
// RL14 - key tied low disables pin wake from deep sleep
// RL15 - with key tied low host sends shutdown then removes supply
// RL16 - unconditional shutdown line resets and halts; release powers down without detach
// RL17 - host uses unconditional shutdown only as emergency exit
// RL18 - host drives no high levels onto pins while off or transitioning
// RL19 - key pulse widths and indicator delay are block parameters
// RL20 - key and fast-shutdown pins synchronised before detection
module mpsc_power_ctrl #(
  parameter int unsigned KEY_ON_CYC = mpsc_pkg::KEY_ON_CYC,
  parameter int unsigned KEY_OFF_CYC = mpsc_pkg::KEY_OFF_CYC,
  parameter int unsigned WAKE_HOLD_CYC = mpsc_pkg::WAKE_HOLD_CYC,
  parameter int unsigned IND_DELAY_CYC = mpsc_pkg::IND_DELAY_CYC
) (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic main_supply_in,
  input wire logic power_key_n_in,
  input wire logic fsd_pin_in,
  input wire logic fsd_pin_enable_in,
  input wire logic uncond_shdn_n_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  input wire logic update_timer_expired_in,
  input wire logic scheduled_wake_in,
  input wire logic detach_done_in,
  input wire logic storage_closed_in,
  output logic power_on_indicator_out,
  output logic baseband_power_out,
  output logic rtc_run_out,
  output logic cpu_run_out,
  output logic core_reset_out,
  output logic net_detach_req_out,
  output logic storage_close_req_out,
  output logic cmd_ack_out,
  output logic deep_cfg_out,
  output logic [3:0] state_out
);
  // ****************************************
  // pin synchronisation
  // ****************************************
  mpsc_sync_if sync_bus ();

  assign sync_bus.raw = {uncond_shdn_n_in, fsd_pin_in, power_key_n_in};

  // RL20 synchronise pins
  mpsc_pin_sync u_sync (
    .clk_in(ref_clk_in),
    .rst_in(sys_rst_in),
    .pins(sync_bus.sync_side)
  );

  wire key_low = ~sync_bus.sync[mpsc_pkg::SYNC_KEY];
  wire fsd_lvl = sync_bus.sync[mpsc_pkg::SYNC_FSD];
  wire hsd_low = ~sync_bus.sync[mpsc_pkg::SYNC_HSD];

  // ****************************************
  // state and helpers
  // ****************************************
  mpsc_pkg::mpsc_state_t state_reg;
  mpsc_pkg::mpsc_state_t state_next;
  logic [mpsc_pkg::CNT_W-1:0] key_cnt_reg;
  logic [mpsc_pkg::CNT_W-1:0] boot_cnt_reg;
  logic [7:0] duty_cnt_reg;
  logic key_armed_reg;
  logic fsd_prev_reg;
  logic deep_cfg_reg;
  logic ack_reg;
  logic ind_reg;
  logic bb_reg;
  logic cpu_reg;
  logic crst_reg;
  logic det_reg;
  logic stc_reg;
  logic rtc_reg;

  // a key held low since reset is never armed, so a tied-low key cannot act
  wire key_counting = key_low & key_armed_reg;
  wire key_on_hit = key_counting & (key_cnt_reg >= KEY_ON_CYC[mpsc_pkg::CNT_W-1:0]);
  wire key_off_hit = key_counting & (key_cnt_reg >= KEY_OFF_CYC[mpsc_pkg::CNT_W-1:0]);
  wire key_wake_hit = key_counting & (key_cnt_reg >= WAKE_HOLD_CYC[mpsc_pkg::CNT_W-1:0]);
  wire boot_done = boot_cnt_reg >= IND_DELAY_CYC[mpsc_pkg::CNT_W-1:0];

  // RL9 enabled falling edge
  wire fsd_fall = fsd_pin_enable_in & fsd_prev_reg & ~fsd_lvl;

  // RL3 intermittent processor
  wire sleep_awake = duty_cnt_reg < mpsc_pkg::SLEEP_AWAKE_CYC;

  // RL2 commands in on state
  wire cmd_take = cmd_valid_in & ~ack_reg &
                  ((state_reg == mpsc_pkg::ST_ON) |
                   ((state_reg == mpsc_pkg::ST_SLEEP) & sleep_awake));
  wire cmd_shdn = cmd_take & (cmd_code_in == mpsc_pkg::CMD_SHUTDOWN);
  wire cmd_fast = cmd_take & (cmd_code_in == mpsc_pkg::CMD_FAST_SHUTDOWN);
  wire cmd_cfg_on = cmd_take & (cmd_code_in == mpsc_pkg::CMD_DEEP_CFG_ON);
  wire cmd_cfg_off = cmd_take & (cmd_code_in == mpsc_pkg::CMD_DEEP_CFG_OFF);
  wire cmd_sleep = cmd_take & (cmd_code_in == mpsc_pkg::CMD_SLEEP);
  wire cmd_wake = cmd_take & (cmd_code_in == mpsc_pkg::CMD_WAKE);

  wire awake_state = (state_reg == mpsc_pkg::ST_ON) | (state_reg == mpsc_pkg::ST_SLEEP);
  // RL16 not honoured while off, booting or in deep sleep
  wire uncond_go = hsd_low & (awake_state |
                   (state_reg == mpsc_pkg::ST_DETACH) |
                   (state_reg == mpsc_pkg::ST_FS_CLOSE) |
                   (state_reg == mpsc_pkg::ST_FAST));

  // ****************************************
  // next-state decode
  // ****************************************
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      mpsc_pkg::ST_OFF: begin
        // RL1 only exit is power-on
        if (key_on_hit) begin
          state_next = mpsc_pkg::ST_BOOT;
        end
      end
      mpsc_pkg::ST_BOOT: begin
        // RL19 indicator delay
        if (boot_done) begin
          state_next = mpsc_pkg::ST_ON;
        end
      end
      mpsc_pkg::ST_ON, mpsc_pkg::ST_SLEEP: begin
        if (uncond_go) begin
          state_next = mpsc_pkg::ST_UNCOND;
        end else if (fsd_fall | cmd_fast) begin
          // RL11 fast shutdown command
          state_next = mpsc_pkg::ST_FAST;
        end else if (cmd_shdn | key_off_hit) begin
          // RL13 command or key sequence
          state_next = mpsc_pkg::ST_DETACH;
        end else if (update_timer_expired_in & deep_cfg_reg) begin
          // RL4 enter deep sleep
          state_next = mpsc_pkg::ST_DEEP;
        end else if (cmd_sleep) begin
          state_next = mpsc_pkg::ST_SLEEP;
        end else if (cmd_wake) begin
          state_next = mpsc_pkg::ST_ON;
        end
      end
      mpsc_pkg::ST_DEEP: begin
        // RL5 long key hold wakes
        if (key_wake_hit | scheduled_wake_in) begin
          state_next = mpsc_pkg::ST_BOOT;
        end
      end
      mpsc_pkg::ST_DETACH: begin
        // RL12 detach before closing storage
        if (uncond_go) begin
          state_next = mpsc_pkg::ST_UNCOND;
        end else if (detach_done_in) begin
          state_next = mpsc_pkg::ST_FS_CLOSE;
        end
      end
      mpsc_pkg::ST_FS_CLOSE, mpsc_pkg::ST_FAST: begin
        // RL10 storage closed then off
        if (uncond_go) begin
          state_next = mpsc_pkg::ST_UNCOND;
        end else if (storage_closed_in) begin
          state_next = mpsc_pkg::ST_OFF;
        end
      end
      mpsc_pkg::ST_UNCOND: begin
        // RL16 release powers down
        if (!hsd_low) begin
          state_next = mpsc_pkg::ST_OFF;
        end
      end
      default: begin
        state_next = mpsc_pkg::ST_OFF;
      end
    endcase
    // RL8 supply loss forces off
    if (!main_supply_in) begin
      state_next = mpsc_pkg::ST_OFF;
    end
  end

  wire next_awake = (state_next == mpsc_pkg::ST_ON) | (state_next == mpsc_pkg::ST_SLEEP);
  wire next_closing = (state_next == mpsc_pkg::ST_DETACH) |
                      (state_next == mpsc_pkg::ST_FS_CLOSE) |
                      (state_next == mpsc_pkg::ST_FAST);
  // RL7 indicator high when powered, low during boot delay
  wire ind_next = next_awake | next_closing | (state_next == mpsc_pkg::ST_UNCOND);
  // RL1 baseband off in off and deep sleep
  wire bb_next = ind_next | (state_next == mpsc_pkg::ST_BOOT);
  wire cpu_next = (state_next == mpsc_pkg::ST_SLEEP) ? sleep_awake : bb_next;
  wire key_cnt_clr = ~key_counting | (state_next != state_reg);

  // ****************************************
  // registers
  // ****************************************
  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      state_reg <= mpsc_pkg::ST_OFF;
      key_cnt_reg <= '0;
      boot_cnt_reg <= '0;
      duty_cnt_reg <= '0;
      key_armed_reg <= 1'b0;
      fsd_prev_reg <= 1'b1;
      deep_cfg_reg <= 1'b0;
      ack_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      fsd_prev_reg <= fsd_lvl;
      ack_reg <= cmd_take;
      // RL14 re-arm only after release
      if (!key_low) begin
        key_armed_reg <= 1'b1;
      end else if (state_next != state_reg) begin
        key_armed_reg <= 1'b0;
      end
      key_cnt_reg <= key_cnt_clr ? '0 : key_cnt_reg + 1'b1;
      boot_cnt_reg <= (state_reg == mpsc_pkg::ST_BOOT) ? boot_cnt_reg + 1'b1 : '0;
      duty_cnt_reg <= (duty_cnt_reg >= mpsc_pkg::SLEEP_PERIOD_CYC) ? '0 : duty_cnt_reg + 1'b1;
      // RL6 deep sleep only after configuration
      if (!main_supply_in | cmd_cfg_off) begin
        deep_cfg_reg <= 1'b0;
      end else if (cmd_cfg_on) begin
        deep_cfg_reg <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (sys_rst_in) begin
      ind_reg <= 1'b0;
      bb_reg <= 1'b0;
      cpu_reg <= 1'b0;
      crst_reg <= 1'b0;
      det_reg <= 1'b0;
      stc_reg <= 1'b0;
    end else begin
      ind_reg <= ind_next;
      bb_reg <= bb_next;
      cpu_reg <= cpu_next;
      // RL16 reset and halt
      crst_reg <= state_next == mpsc_pkg::ST_UNCOND;
      det_reg <= state_next == mpsc_pkg::ST_DETACH;
      stc_reg <= (state_next == mpsc_pkg::ST_FS_CLOSE) | (state_next == mpsc_pkg::ST_FAST);
    end
  end

  // no reset: the clock lives on supply alone, not on core reset
  always_ff @(posedge ref_clk_in) begin
    rtc_reg <= main_supply_in;
  end

  // ****************************************
  // outputs
  // ****************************************
  assign power_on_indicator_out = ind_reg;
  assign baseband_power_out = bb_reg;
  // RL8 clock follows supply
  assign rtc_run_out = rtc_reg;
  assign cpu_run_out = cpu_reg;
  assign core_reset_out = crst_reg;
  assign net_detach_req_out = det_reg;
  assign storage_close_req_out = stc_reg;
  assign cmd_ack_out = ack_reg;
  assign deep_cfg_out = deep_cfg_reg;
  assign state_out = state_reg;
endmodule // mpsc_power_ctrl

// File: test/mpsc_power_ctrl_asserts.sv
module mpsc_power_ctrl_asserts (
  input wire logic ref_clk_in,
  input wire logic sys_rst_in,
  input wire logic main_supply_in,
  input wire logic cmd_valid_in,
  input wire logic [2:0] cmd_code_in,
  input wire logic power_on_indicator_out,
  input wire logic baseband_power_out,
  input wire logic rtc_run_out,
  input wire logic core_reset_out,
  input wire logic net_detach_req_out,
  input wire logic storage_close_req_out,
  input wire logic cmd_ack_out,
  input wire logic deep_cfg_out,
  input wire logic [3:0] state_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // power state checks
  // ****
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (sys_rst_in);
  AST_IND_STATE: assert property (
    power_on_indicator_out == (state_out inside {4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8}))
    else $error("indicator disagrees with state");
  AST_RTC_SUPPLY: assert property (rtc_run_out == $past(main_supply_in))
    else $error("clock run differs from supply");
  AST_OFF_DARK: assert property (
    state_out == 4'h0 |-> !baseband_power_out && !power_on_indicator_out)
    else $error("power present while off");
  AST_OFF_EXIT: assert property (
    $past(state_out) == 4'h0 && state_out != 4'h0 |-> state_out == 4'h1)
    else $error("off left to a state other than boot");
  AST_DEEP_DARK: assert property (
    state_out == 4'h4 |-> !baseband_power_out && deep_cfg_out)
    else $error("deep sleep powered or unconfigured");
  AST_FAST_NO_DETACH: assert property (
    state_out == 4'h7 |-> storage_close_req_out && !net_detach_req_out)
    else $error("fast shutdown requests detach");
  AST_ACK_PULSE: assert property (
    cmd_ack_out |-> $past(cmd_valid_in) ##1 !cmd_ack_out)
    else $error("ack without request or too long");
  AST_SHDN_DETACH: assert property (
    cmd_ack_out && $past(cmd_code_in) == 3'h1 |-> state_out == 4'h5 && net_detach_req_out)
    else $error("shutdown did not start detach");
  AST_UNCOND_HALT: assert property (
    state_out == 4'h8 |-> core_reset_out && !net_detach_req_out)
    else $error("unconditional halt wrong");
  AST_SUPPLY_OFF: assert property (
    !main_supply_in |=> state_out == 4'h0 && !deep_cfg_out)
    else $error("supply loss did not clear");
endmodule // mpsc_power_ctrl_asserts

bind mpsc_power_ctrl mpsc_power_ctrl_asserts mpsc_power_ctrl_asserts_i (
  .ref_clk_in, .sys_rst_in, .main_supply_in, .cmd_valid_in, .cmd_code_in,
  .power_on_indicator_out, .baseband_power_out, .rtc_run_out, .core_reset_out,
  .net_detach_req_out, .storage_close_req_out, .cmd_ack_out, .deep_cfg_out, .state_out);

// File: test/mpsc_host_model.sv
module mpsc_host_model (
  input wire logic clk_in,
  input wire logic net_detach_req_in,
  input wire logic storage_close_req_in,
  output logic power_key_n_out,
  output logic detach_done_out,
  output logic storage_closed_out
);
  timeunit 1ns;
  timeprecision 1ps;
  // ****
  // host key and completion answers
  // ****
  int resp_dly = 2;
  int det_cnt = 0;
  int fs_cnt = 0;
  initial begin
    power_key_n_out = 1'b1;
    detach_done_out = 1'b0;
    storage_closed_out = 1'b0;
  end
  always @(negedge clk_in) begin
    det_cnt = net_detach_req_in ? det_cnt + 1 : 0;
    fs_cnt = storage_close_req_in ? fs_cnt + 1 : 0;
    detach_done_out <= (det_cnt == resp_dly);
    storage_closed_out <= (fs_cnt == resp_dly);
  end
  task automatic press(input int n);
    power_key_n_out = 1'b0;
    repeat (n) @(negedge clk_in);
    power_key_n_out = 1'b1;
  endtask
endmodule // mpsc_host_model

// File: test/mpsc_power_ctrl_tb.sv
module mpsc_power_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic ref_clk_in = 1'b0;
  logic sys_rst_in;
  logic main_supply_in;
  logic fsd_pin_in;
  logic fsd_pin_enable_in;
  logic uncond_shdn_n_in;
  logic cmd_valid_in;
  logic [2:0] cmd_code_in;
  logic update_timer_expired_in;
  logic scheduled_wake_in;
  logic power_key_n_in, detach_done_in, storage_closed_in, power_on_indicator_out;
  logic baseband_power_out, rtc_run_out, cpu_run_out, core_reset_out;
  logic net_detach_req_out, storage_close_req_out, cmd_ack_out, deep_cfg_out;
  logic [3:0] state_out;
  int fail_count = 0;
  int compares = 0;
  mpsc_power_ctrl #(.KEY_ON_CYC(20), .KEY_OFF_CYC(30), .WAKE_HOLD_CYC(50), .IND_DELAY_CYC(5))
    mpsc_power_ctrl_i (.ref_clk_in, .sys_rst_in, .main_supply_in, .power_key_n_in, .fsd_pin_in,
    .fsd_pin_enable_in, .uncond_shdn_n_in, .cmd_valid_in, .cmd_code_in, .update_timer_expired_in,
    .scheduled_wake_in, .detach_done_in, .storage_closed_in, .power_on_indicator_out,
    .baseband_power_out, .rtc_run_out, .cpu_run_out, .core_reset_out, .net_detach_req_out,
    .storage_close_req_out, .cmd_ack_out, .deep_cfg_out, .state_out);
  mpsc_host_model mpsc_host_model_i (.clk_in(ref_clk_in), .net_detach_req_in(net_detach_req_out),
    .storage_close_req_in(storage_close_req_out), .power_key_n_out(power_key_n_in),
    .detach_done_out(detach_done_in), .storage_closed_out(storage_closed_in));
  initial forever #2 ref_clk_in = ~ref_clk_in;
  // ****
  // helpers
  // ****
  task automatic chk(input string nm, input logic [3:0] e, input logic [3:0] g);
    compares++;
    if (g !== e) begin
      fail_count++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic end_sim();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // bounded wait, a miss ends the run
  task automatic wait_st(input logic [3:0] s, input int n);
    for (int i = 0; i < n && state_out !== s; i++) @(negedge ref_clk_in);
    chk("state", s, state_out);
    if (state_out !== s) end_sim();
  endtask
  task automatic cmd(input logic [2:0] c);
    cmd_code_in = c;
    cmd_valid_in = 1'b1;
    for (int i = 0; i < 300 && cmd_ack_out !== 1'b1; i++) @(negedge ref_clk_in);
    chk("ack", 4'h1, {3'h0, cmd_ack_out});
    cmd_valid_in = 1'b0;
    if (cmd_ack_out !== 1'b1) end_sim();
    @(negedge ref_clk_in);
  endtask
  task automatic p_on();
    mpsc_host_model_i.press(24);
    wait_st(4'h2, 40);
  endtask
  task automatic pulse_timer();
    update_timer_expired_in = 1'b1;
    @(negedge ref_clk_in);
    update_timer_expired_in = 1'b0;
    repeat (3) @(negedge ref_clk_in);
  endtask
  // ****
  // scenarios
  // ****
  task automatic s_on_shdn();
    mpsc_host_model_i.press(10);
    repeat (5) @(negedge ref_clk_in);
    chk("short press", 4'h0, state_out);
    p_on();
    chk("ind", 4'h1, {3'h0, power_on_indicator_out});
    chk("cpu on", 4'h1, {3'h0, cpu_run_out});
    cmd(3'h5);
    chk("sleep", 4'h3, state_out);
    for (int i = 0; i < 300 && cpu_run_out !== 1'b0; i++) @(negedge ref_clk_in);
    chk("cpu sleep", 4'h0, {3'h0, cpu_run_out});
    cmd(3'h6);
    chk("awake", 4'h2, state_out);
    mpsc_host_model_i.resp_dly = 20;
    cmd(3'h1);
    chk("detach", 4'h1, {3'h0, net_detach_req_out});
    wait_st(4'h6, 60);
    wait_st(4'h0, 60);
    mpsc_host_model_i.resp_dly = 2;
    p_on();
    mpsc_host_model_i.press(40);
    wait_st(4'h0, 60);
    repeat (4) @(negedge ref_clk_in);
  endtask
  task automatic s_deep();
    p_on();
    pulse_timer();
    chk("no cfg", 4'h2, state_out);
    cmd(3'h3);
    pulse_timer();
    chk("deep", 4'h4, state_out);
    chk("ind deep", 4'h0, {3'h0, power_on_indicator_out});
    chk("bb deep", 4'h0, {3'h0, baseband_power_out});
    mpsc_host_model_i.press(30);
    repeat (4) @(negedge ref_clk_in);
    chk("short wake", 4'h4, state_out);
    mpsc_host_model_i.press(60);
    wait_st(4'h2, 40);
    pulse_timer();
    scheduled_wake_in = 1'b1;
    @(negedge ref_clk_in);
    scheduled_wake_in = 1'b0;
    wait_st(4'h2, 40);
    cmd(3'h4);
    chk("cfg off", 4'h0, {3'h0, deep_cfg_out});
    pulse_timer();
    chk("no deep", 4'h2, state_out);
  endtask
  task automatic s_fast();
    fsd_pin_in = 1'b0;
    repeat (6) @(negedge ref_clk_in);
    chk("fsd off", 4'h2, state_out);
    fsd_pin_in = 1'b1;
    fsd_pin_enable_in = 1'b1;
    repeat (4) @(negedge ref_clk_in);
    fsd_pin_in = 1'b0;
    wait_st(4'h7, 10);
    wait_st(4'h0, 20);
    fsd_pin_in = 1'b1;
    fsd_pin_enable_in = 1'b0;
    p_on();
    cmd(3'h2);
    chk("fast cmd", 4'h7, state_out);
    chk("fast close", 4'h1, {3'h0, storage_close_req_out});
    wait_st(4'h0, 20);
  endtask
  task automatic s_uncond_supply();
    p_on();
    uncond_shdn_n_in = 1'b0;
    wait_st(4'h8, 10);
    chk("core rst", 4'h1, {3'h0, core_reset_out});
    uncond_shdn_n_in = 1'b1;
    wait_st(4'h0, 10);
    p_on();
    cmd(3'h3);
    cmd(3'h1);
    main_supply_in = 1'b0;
    wait_st(4'h0, 5);
    chk("rtc", 4'h0, {3'h0, rtc_run_out});
    chk("cfg lost", 4'h0, {3'h0, deep_cfg_out});
    main_supply_in = 1'b1;
    mpsc_host_model_i.power_key_n_out = 1'b0;
    sys_rst_in = 1'b1;
    repeat (20) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    repeat (60) @(negedge ref_clk_in);
    chk("key tied", 4'h0, state_out);
    mpsc_host_model_i.power_key_n_out = 1'b1;
  endtask
  initial begin
    sys_rst_in = 1'b1;
    main_supply_in = 1'b1;
    fsd_pin_in = 1'b1;
    fsd_pin_enable_in = 1'b0;
    uncond_shdn_n_in = 1'b1;
    cmd_valid_in = 1'b0;
    cmd_code_in = 3'h0;
    update_timer_expired_in = 1'b0;
    scheduled_wake_in = 1'b0;
    repeat (20) @(negedge ref_clk_in);
    sys_rst_in = 1'b0;
    s_on_shdn();
    s_deep();
    s_fast();
    s_uncond_supply();
    end_sim();
  end
endmodule // mpsc_power_ctrl_tb
